/* File: rtl/qcl_params.svh */
`ifndef QCL_PARAMS_SVH
`define QCL_PARAMS_SVH

// ============================================================
// Widths and counts
`define QCL_CHANNELS 5
`define QCL_COUNT_WIDTH 24
`define QCL_COUNT_RESET 24'h000000
`define QCL_LATCH_RESET 24'h000000

// ============================================================
// Timing
`define QCL_CLK_MHZ 100
`define QCL_MAX_COUNT_RATE_HZ 1000000
`define QCL_MIN_COUNT_PERIOD_NS (1000000000 / `QCL_MAX_COUNT_RATE_HZ)
`define QCL_MIN_COUNT_CYCLES ((`QCL_MIN_COUNT_PERIOD_NS * `QCL_CLK_MHZ) / 1000)

`endif

/* File: rtl/qcl_pkg.sv */
package qcl_pkg;
	typedef enum logic [1:0] {
		QCL_MODE_OFF,
		QCL_MODE_INDEX,
		QCL_MODE_FAST,
		QCL_MODE_ARMED_INDEX
	} qcl_mode_t;

	typedef enum logic {
		QCL_EDGE_RISING,
		QCL_EDGE_FALLING
	} qcl_edge_t;
endpackage

/* File: rtl/qcl_channel.sv */
`timescale 1ns/1ps
`include "qcl_params.svh"

module qcl_channel #(
	parameter int WIDTH = `QCL_COUNT_WIDTH
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	input wire logic i_enc_index,
	input wire logic i_fast,
	input wire qcl_pkg::qcl_mode_t i_mode,
	input wire qcl_pkg::qcl_edge_t i_fast_edge,
	output logic [WIDTH-1:0] o_count,
	output logic [WIDTH-1:0] o_latch,
	output logic o_latched,
	output logic o_armed,
	output logic o_count_error
);
	import qcl_pkg::*;

	// ============================================================
	// Input synchronisers
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] prev_reg;
	logic [3:0] raw_in;

	assign raw_in = {i_fast, i_enc_index, i_enc_b, i_enc_a};

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			prev_reg <= 4'h0;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	logic a_s;
	logic b_s;
	logic a_p;
	logic b_p;
	logic index_rise;
	logic fast_rise;
	logic fast_fall;
	logic fast_hit;

	assign a_s = sync2_reg[0];
	assign b_s = sync2_reg[1];
	assign a_p = prev_reg[0];
	assign b_p = prev_reg[1];
	assign index_rise = sync2_reg[2] & ~prev_reg[2];
	assign fast_rise = sync2_reg[3] & ~prev_reg[3];
	assign fast_fall = ~sync2_reg[3] & prev_reg[3];
	assign fast_hit = (i_fast_edge == QCL_EDGE_RISING) ? fast_rise : fast_fall;

	// ============================================================
	// Quadrature decode and counter
	// Both lines changing in one sample means the input outran the decoder,
	// so the step is dropped and flagged rather than guessed.
	logic a_chg;
	logic b_chg;
	logic step_up;
	logic step_dn;
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic err_reg;
	logic err_next;

	assign a_chg = a_s ^ a_p;
	assign b_chg = b_s ^ b_p;
	// A leading B: A changes to differ from B, or B changes to match A.
	assign step_up = (a_chg & ~b_chg & (a_s != b_s)) | (b_chg & ~a_chg & (a_s == b_s));
	assign step_dn = (a_chg & ~b_chg & (a_s == b_s)) | (b_chg & ~a_chg & (a_s != b_s));

	always_comb begin
		count_next = count_reg;
		err_next = err_reg | (a_chg & b_chg);
		if (step_up) begin
			count_next = count_reg + WIDTH'(1);
		end else if (step_dn) begin
			count_next = count_reg - WIDTH'(1);
		end
	end

	// ============================================================
	// Capture
	logic armed_reg;
	logic armed_next;
	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] latch_next;
	logic latched_reg;
	logic latched_next;
	logic capture;

	always_comb begin
		capture = 1'b0;
		armed_next = armed_reg;
		unique case (i_mode)
			QCL_MODE_OFF: begin
				armed_next = 1'b0;
			end
			QCL_MODE_INDEX: begin
				armed_next = 1'b0;
				capture = index_rise;
			end
			QCL_MODE_FAST: begin
				armed_next = 1'b0;
				capture = fast_hit;
			end
			QCL_MODE_ARMED_INDEX: begin
				capture = armed_reg & index_rise;
				if (capture) begin
					armed_next = 1'b0;
				end else if (fast_hit) begin
					armed_next = 1'b1;
				end
			end
		endcase
		latch_next = capture ? count_reg : latch_reg;
		latched_next = capture;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			count_reg <= `QCL_COUNT_RESET;
			err_reg <= 1'b0;
			armed_reg <= 1'b0;
			latch_reg <= `QCL_LATCH_RESET;
			latched_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			err_reg <= err_next;
			armed_reg <= armed_next;
			latch_reg <= latch_next;
			latched_reg <= latched_next;
		end
	end

	assign o_count = count_reg;
	assign o_latch = latch_reg;
	assign o_latched = latched_reg;
	assign o_armed = armed_reg;
	assign o_count_error = err_reg;

	// ============================================================
	// Checks
	sequence fast_seen_s;
		fast_hit && i_mode == QCL_MODE_ARMED_INDEX;
	endsequence

	count_up_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
		step_up |=> count_reg == $past(count_reg) + WIDTH'(1))
		else $error("count did not step up");
	count_dn_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
		step_dn |=> count_reg == $past(count_reg) - WIDTH'(1))
		else $error("count did not step down");
	count_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!step_up && !step_dn |=> $stable(count_reg))
		else $error("count moved without an edge");
	index_capture_a: assert property (@(posedge i_clk) disable iff (i_reset)
		i_mode == QCL_MODE_INDEX && index_rise |=> latch_reg == $past(count_reg))
		else $error("index capture missed");
	fast_capture_a: assert property (@(posedge i_clk) disable iff (i_reset)
		i_mode == QCL_MODE_FAST && fast_hit |=> latch_reg == $past(count_reg) && latched_reg)
		else $error("fast capture missed");
	arm_sets_a: assert property (@(posedge i_clk) disable iff (i_reset)
		fast_seen_s and !capture |=> armed_reg)
		else $error("fast edge did not arm");
	unarmed_index_a: assert property (@(posedge i_clk) disable iff (i_reset)
		i_mode == QCL_MODE_ARMED_INDEX && !armed_reg && index_rise |=> !latched_reg)
		else $error("index captured before arming");
	latch_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		!capture |=> $stable(latch_reg) && !latched_reg)
		else $error("latch changed without capture");
	sync_delay_a: assert property (@(posedge i_clk) disable iff (i_reset)
		1'b1 ##2 1'b1 |-> a_s == $past(i_enc_a, 2))
		else $error("synchroniser depth wrong");
endmodule

/* File: rtl/qcl_top.sv */
`timescale 1ns/1ps
`include "qcl_params.svh"

module qcl_top #(
	parameter int CHANNELS = `QCL_CHANNELS,
	parameter int WIDTH = `QCL_COUNT_WIDTH
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [CHANNELS-1:0] i_enc_a,
	input wire logic [CHANNELS-1:0] i_enc_b,
	input wire logic [CHANNELS-1:0] i_enc_index,
	input wire logic [CHANNELS-1:0] i_fast,
	input wire qcl_pkg::qcl_mode_t i_mode [CHANNELS],
	input wire qcl_pkg::qcl_edge_t i_fast_edge [CHANNELS],
	output logic [WIDTH-1:0] o_count [CHANNELS],
	output logic [WIDTH-1:0] o_latch [CHANNELS],
	output logic [CHANNELS-1:0] o_latched,
	output logic [CHANNELS-1:0] o_armed,
	output logic [CHANNELS-1:0] o_count_error
);
	import qcl_pkg::*;

	// ============================================================
	// Channels
	// One decoder per channel sustains a step every four clocks at least,
	// far above the line rate the encoder may produce.
	localparam int MIN_CYCLES = `QCL_MIN_COUNT_CYCLES;
	initial begin
		if (MIN_CYCLES < 4) begin
			$error("clock too slow for the count rate");
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
			qcl_channel #(
				.WIDTH(WIDTH)
			) u_channel (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_enc_a(i_enc_a[ch]),
				.i_enc_b(i_enc_b[ch]),
				.i_enc_index(i_enc_index[ch]),
				.i_fast(i_fast[ch]),
				.i_mode(i_mode[ch]),
				.i_fast_edge(i_fast_edge[ch]),
				.o_count(o_count[ch]),
				.o_latch(o_latch[ch]),
				.o_latched(o_latched[ch]),
				.o_armed(o_armed[ch]),
				.o_count_error(o_count_error[ch])
			);
		end
	endgenerate
endmodule

/* File: verification/qcl_encoder_model.sv */
`timescale 1ns/1ps
// ==========================================
// Encoder and fast reference input model
module qcl_encoder_model (
	input wire logic i_clk,
	output logic [4:0] o_a,
	output logic [4:0] o_b,
	output logic [4:0] o_index,
	output logic [4:0] o_fast
);
	logic [1:0] phase [5] = '{default: 2'h0};
	initial begin
		o_a = 5'h00;
		o_b = 5'h00;
		o_index = 5'h00;
		o_fast = 5'h00;
	end
	// A hundred quiet clocks after each edge, 101 in all, keep the line rate just under its ceiling.
	task automatic step(input int ch, input logic up, input logic both);
		@(posedge i_clk);
		#1;
		if (both) begin
			o_a[ch] = ~o_a[ch];
			o_b[ch] = ~o_b[ch];
		end else begin
			phase[ch] = up ? phase[ch] + 2'h1 : phase[ch] - 2'h1;
			o_a[ch] = phase[ch][1] ^ phase[ch][0];
			o_b[ch] = phase[ch][1];
		end
		repeat (100) @(posedge i_clk);
	endtask
	task automatic pin(input logic fast, input int ch, input logic v);
		@(posedge i_clk);
		#1;
		if (fast) o_fast[ch] = v;
		else o_index[ch] = v;
		repeat (8) @(posedge i_clk);
	endtask
endmodule

/* File: verification/quadrature_counter_latch_test.sv */
`timescale 1ns/1ps
module quadrature_counter_latch_test;
	import qcl_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [4:0] a, b, idx, fst, latched, armed, err;
	qcl_mode_t mode [5] = '{default: QCL_MODE_OFF};
	qcl_edge_t edge_sel [5] = '{default: QCL_EDGE_RISING};
	logic [23:0] cnt [5];
	logic [23:0] lat [5];
	logic [23:0] exp_cnt [5] = '{default: 24'h000000};
	int n_lat [5] = '{default: 0};
	int n_mismatch = 0;
	int total_checks = 0;
	always #5 i_clk = ~i_clk;
	qcl_encoder_model enc (.i_clk(i_clk), .o_a(a), .o_b(b), .o_index(idx), .o_fast(fst));
	qcl_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_enc_a(a), .i_enc_b(b),
		.i_enc_index(idx), .i_fast(fst), .i_mode(mode), .i_fast_edge(edge_sel),
		.o_count(cnt), .o_latch(lat), .o_latched(latched), .o_armed(armed),
		.o_count_error(err));
	// The capture flag stands one cycle only, so it is counted on every edge.
	always @(posedge i_clk) begin
		for (int c = 0; c < 5; c++) if (latched[c] === 1'b1) n_lat[c]++;
	end
	// ==========================================
	// Shared tasks
	task automatic check(input logic [23:0] seen, input logic [23:0] expd);
		total_checks++;
		if (seen !== expd) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expd);
		end
	endtask
	task automatic mv(input int ch, input logic up, input int n);
		repeat (n) begin
			enc.step(ch, up, 1'b0);
			exp_cnt[ch] = up ? exp_cnt[ch] + 24'h000001 : exp_cnt[ch] - 24'h000001;
		end
	endtask
	task automatic set_mode(input int ch, input qcl_mode_t m, input qcl_edge_t e);
		@(posedge i_clk);
		#1;
		mode[ch] = m;
		edge_sel[ch] = e;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_count();
		for (int c = 0; c < 5; c++) begin
			mv(c, 1'b1, c + 2);
			check(cnt[c], exp_cnt[c]);
		end
		mv(0, 1'b0, 4);
		check(cnt[0], 24'hFFFFFE);
	endtask
	task automatic t_index();
		set_mode(1, QCL_MODE_INDEX, QCL_EDGE_RISING);
		enc.pin(1'b0, 2, 1'b1);
		enc.pin(1'b0, 2, 1'b0);
		enc.pin(1'b0, 1, 1'b1);
		check(lat[1], exp_cnt[1]);
		enc.pin(1'b0, 1, 1'b0);
		check(24'(n_lat[1]), 24'h000001);
		check(24'(n_lat[2]), 24'h000000);
	endtask
	// Moving between the two edges tells which edge took the copy.
	task automatic t_fast();
		for (int e = 0; e < 2; e++) begin
			set_mode(2, QCL_MODE_FAST, qcl_edge_t'(e));
			n_lat[2] = 0;
			enc.pin(1'b1, 2, 1'b1);
			mv(2, 1'b1, 3);
			enc.pin(1'b1, 2, 1'b0);
			check(lat[2], (e == 1) ? exp_cnt[2] : exp_cnt[2] - 24'h000003);
			check(24'(n_lat[2]), 24'h000001);
		end
	endtask
	task automatic t_armed();
		set_mode(3, QCL_MODE_ARMED_INDEX, QCL_EDGE_FALLING);
		enc.pin(1'b0, 3, 1'b1);
		enc.pin(1'b0, 3, 1'b0);
		check(24'(n_lat[3]), 24'h000000);
		enc.pin(1'b1, 3, 1'b1);
		check({23'h000000, armed[3]}, 24'h000000);
		enc.pin(1'b1, 3, 1'b0);
		check({23'h000000, armed[3]}, 24'h000001);
		mv(3, 1'b0, 2);
		enc.pin(1'b0, 3, 1'b1);
		check(lat[3], exp_cnt[3]);
		check({23'h000000, armed[3]}, 24'h000000);
		enc.pin(1'b0, 3, 1'b0);
		check(24'(n_lat[3]), 24'h000001);
	endtask
	task automatic t_error();
		enc.step(4, 1'b0, 1'b1);
		check(cnt[4], exp_cnt[4]);
		check({23'h000000, err[4]}, 24'h000001);
		check({20'h00000, err[3:0]}, 24'h000000);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		#1;
		i_reset = 1'b0;
		check(cnt[0], 24'h000000);
		check(lat[0], 24'h000000);
		t_count();
		t_index();
		t_fast();
		t_armed();
		t_error();
		print_verdict();
	end
endmodule
